// >>> verilog/bpf_pkg.sv
// shared constants and types for the back-emf loop filter and overcurrent gate
`default_nettype none
// Overview of operation
// - overcurrent blanks drive until a cycle start with the comparator quiet
// - recurring overcurrent escalates to latched hard shutdown
// - comparator gates pwm directly, no adc path
// - blanking path works with clock stopped
// - output is prior output plus weighted sample terms
// - keep new output and sample as state
// - input is newest bus-midpoint referenced adc sample
// - coefficients from period and two time constants
// - timer stamps each back-emf event, top priority
package bpf_pkg;
   // sample, coefficient, output, stamp and counter widths
   localparam int BPF_SAMPLE_W = 12;
   localparam int BPF_COEF_W   = 16;
   localparam int BPF_FRAC_W   = 8;          // coefficient fraction bits
   localparam int BPF_OUT_W    = 24;
   localparam int BPF_STAMP_W  = 16;
   localparam int BPF_CNT_W    = 8;
   // default shutdown threshold in consecutive faulted cycles
   localparam logic [7:0] BPF_TRIP_DEFAULT = 8'h04;
   // adc midpoint: half of the dc bus in unsigned adc counts
   localparam logic [11:0] BPF_MID_CODE = 12'h800;
   // period and time constants in ns, as figures the coefficient builder uses
   localparam real BPF_T_NS    = 50000.0;
   localparam real BPF_TAU1_NS = 200000.0;
   localparam real BPF_TAU2_NS = 100000.0;
   localparam real BPF_SCALE   = 256.0;      // 2**BPF_FRAC_W
   // current weight (t + 2 tau2)/(2 tau1); previous weight -(t - 2 tau2)/(2 tau1)
   localparam int BPF_COEF_CUR_INT =
      int'((BPF_T_NS + 2.0 * BPF_TAU2_NS) / (2.0 * BPF_TAU1_NS) * BPF_SCALE);
   localparam int BPF_COEF_PREV_INT =
      int'(-(BPF_T_NS - 2.0 * BPF_TAU2_NS) / (2.0 * BPF_TAU1_NS) * BPF_SCALE);
   // gate states, gray along run, blank, shutdown
   typedef enum logic [1:0] {
      BPF_RUN   = 2'b00,
      BPF_BLANK = 2'b01,
      BPF_SHUT  = 2'b11
   } bpf_gate_t;
endpackage
`default_nettype wire

// >>> verilog/bpf_sync_if.sv
// interface carrying the synchronised comparator level between modules
`timescale 1ns/10ps
`default_nettype none
interface bpf_sync_if;
   logic level;       // clean comparator level in mclk domain
   logic rise;        // one-cycle pulse when level rises
   modport src (output level, output rise);
   modport dst (input level, input rise);
endinterface
`default_nettype wire

// >>> verilog/bpf_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
`default_nettype none
module bpf_sync (
   input  wire logic  mclk,
   input  wire logic  rst_b,
   input  wire logic  pin,
   bpf_sync_if.src    so
);
   logic s1;          // metastable stage, read only by s2
   logic s2;
   logic s3;
   logic level;       // filtered level
   wire  agree = (s2 == s3);
   // filtered level changes only when second and third stage agree
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (agree) begin
            level <= s3;
         end
      end
   end
   assign so.level = level;
   assign so.rise  = agree & s3 & ~level;
endmodule
`default_nettype wire

// >>> verilog/bpf_top.sv
// back-emf pi loop filter with cycle-by-cycle overcurrent gate
`timescale 1ns/10ps
`default_nettype none
module bpf_top
   import bpf_pkg::*;
#(
   parameter int SAMPLE_W = BPF_SAMPLE_W,
   parameter int OUT_W    = BPF_OUT_W
) (
   input  wire logic                    mclk,
   input  wire logic                    rst_b,
   input  wire logic [SAMPLE_W-1:0]     adc_data,
   input  wire logic                    adc_valid,
   input  wire logic signed [BPF_COEF_W-1:0] coef_current,
   input  wire logic signed [BPF_COEF_W-1:0] coef_previous,
   input  wire logic                    use_default_coef,
   input  wire logic                    pwm_cycle_start,
   input  wire logic [5:0]              pwm_in,
   input  wire logic                    oc_comp,
   input  wire logic [BPF_CNT_W-1:0]    trip_count,
   input  wire logic                    shut_clear,
   output logic [5:0]                   pwm_out,
   output logic signed [OUT_W-1:0]      filter_out_now,
   output logic                         filter_valid,
   output logic [BPF_STAMP_W-1:0]       bemf_stamp,
   output logic                         stamp_valid,
   output logic                         stat_blank,
   output logic                         stat_shut
);
   // product of a signed sample (one extra bit for the midpoint offset) and a
   // coefficient; sized so the difference of two products cannot overflow
   localparam int PROD_W = SAMPLE_W + 1 + BPF_COEF_W;
   // built-in weights from the time constants, in coefficient fixed point
   localparam logic signed [BPF_COEF_W-1:0] COEF_CUR_DEF  = BPF_COEF_W'(BPF_COEF_CUR_INT);
   localparam logic signed [BPF_COEF_W-1:0] COEF_PREV_DEF = BPF_COEF_W'(BPF_COEF_PREV_INT);

   // ---------------- filter ----------------
   logic signed [OUT_W-1:0]    filter_out_prev;   // y(n-1)
   logic signed [SAMPLE_W:0]   sample_prev;       // r(n-1)
   logic [BPF_STAMP_W-1:0]     stamp_timer;       // free-running time base
   // sample referenced to half the bus: signed offset from midpoint
   wire  signed [SAMPLE_W:0]   sample_now =
      $signed({1'b0, adc_data}) - $signed({1'b0, BPF_MID_CODE});
   // coefficient choice: built-in from time constants or supplied
   wire  signed [BPF_COEF_W-1:0] coef_cur_sel  =
      use_default_coef ? COEF_CUR_DEF : coef_current;
   wire  signed [BPF_COEF_W-1:0] coef_prev_sel =
      use_default_coef ? COEF_PREV_DEF : coef_previous;
   wire  signed [PROD_W-1:0]   p_now  = coef_cur_sel * sample_now;
   wire  signed [PROD_W-1:0]   p_prev = coef_prev_sel * sample_prev;
   // scaled difference back to output units; fraction bits dropped
   wire  signed [PROD_W-1:0]   p_diff = (p_now - p_prev) >>> BPF_FRAC_W;
   // new output = prior output + current term - previous term
   wire  signed [OUT_W-1:0]    next_filter_out =
      filter_out_prev + OUT_W'(p_diff);

   // update state once per sample period
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         filter_out_prev <= '0;
         sample_prev     <= '0;
         filter_out_now  <= '0;
         filter_valid    <= 1'b0;
      end else begin
         filter_valid <= adc_valid;
         if (adc_valid) begin
            filter_out_now  <= next_filter_out;
            filter_out_prev <= next_filter_out;
            sample_prev     <= sample_now;
         end
      end
   end

   // time stamp captured at each sensing event, ahead of any other work
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         stamp_timer <= '0;
         bemf_stamp  <= '0;
         stamp_valid <= 1'b0;
      end else begin
         stamp_timer <= stamp_timer + 1'b1;
         stamp_valid <= adc_valid;
         if (adc_valid) begin
            bemf_stamp <= stamp_timer;
         end
      end
   end

   // ---------------- overcurrent gate ----------------
   // the synchronised level feeds only the cycle bookkeeping; the pins are
   // blanked from the raw comparator further down
   bpf_sync_if  oc_if ();
   bpf_sync u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .pin   (oc_comp),
      .so    (oc_if)
   );

   bpf_gate_t               gate;
   logic [BPF_CNT_W-1:0]    hit_cnt;       // consecutive faulted cycles
   logic                    cyc_fault;     // fault seen in this cycle
   wire  fault_now   = oc_if.level | cyc_fault;
   wire  limit_hit   = (hit_cnt + 1'b1) >= trip_count;

   // per-cycle blank, escalate on consecutive faulted cycles
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         gate      <= BPF_RUN;
         hit_cnt   <= '0;
         cyc_fault <= 1'b0;
      end else begin
         unique case (gate)
            BPF_RUN: begin
               if (oc_if.rise) begin
                  gate      <= BPF_BLANK;
                  cyc_fault <= 1'b1;
               end
               if (pwm_cycle_start) begin
                  hit_cnt <= '0;                 // clean cycle breaks the run
               end
            end
            BPF_BLANK: begin
               if (pwm_cycle_start) begin
                  cyc_fault <= oc_if.level;
                  if (limit_hit) begin
                     gate <= BPF_SHUT;
                  end else if (!oc_if.level) begin
                     gate    <= BPF_RUN;         // resume next cycle
                     hit_cnt <= hit_cnt + 1'b1;
                  end else begin
                     hit_cnt <= hit_cnt + 1'b1;
                  end
               end
            end
            BPF_SHUT: begin
               // track the live level so a fault seen in the last blanked
               // cycle cannot keep the latch closed forever
               cyc_fault <= oc_if.level;
               // latched until software clears and fault is gone
               if (shut_clear && !fault_now) begin
                  gate    <= BPF_RUN;
                  hit_cnt <= '0;
               end
            end
            default: gate <= BPF_SHUT;           // illegal code fails safe
         endcase
      end
   end

   // comparator also gates drive without any clock, so a dead clock still
   // blanks; the clocked part stretches the blank to cycle end and holds it through a latched shutdown
   wire clk_blank = (gate != BPF_RUN);
   assign pwm_out    = (oc_comp | clk_blank) ? '0 : pwm_in;
   assign stat_blank = (gate == BPF_BLANK);
   assign stat_shut  = (gate == BPF_SHUT);

   // ---------------- checks ----------------
   // these watch the gate and filter on mclk; the raw comparator path is
   // asynchronous, so the clocked checks only see it at the edges

   // comparator high must always leave every gate driver off
   comb_blank_a: assert property (@(posedge mclk) disable iff (!rst_b)
      oc_comp |-> (pwm_out == '0))
      else $error("drive not blanked");

   // a latched shutdown only leaves on an explicit clear
   shut_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      stat_shut && !shut_clear |=> stat_shut)
      else $error("shutdown lost");

   // no drive at all while the shutdown is latched
   shut_out_a: assert property (@(posedge mclk) disable iff (!rst_b)
      stat_shut |-> pwm_out == '0)
      else $error("drive on in shutdown");

   // a synchronised rising fault in run opens a blanked cycle next edge
   blank_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(oc_if.rise) && gate == BPF_RUN |=> stat_blank)
      else $error("no blank on fault");

   // blanking stands for the rest of the switching cycle
   blank_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      stat_blank && !pwm_cycle_start |=> stat_blank)
      else $error("blank dropped mid cycle");

   // a quiet comparator at the cycle boundary below the threshold restores normal drive
   gate_resume_a: assert property (@(posedge mclk) disable iff (!rst_b)
      stat_blank && pwm_cycle_start && !oc_if.level && !limit_hit |=> gate == BPF_RUN)
      else $error("no resume");

   // in run with a quiet comparator the generator reaches the pins
   run_drive_a: assert property (@(posedge mclk) disable iff (!rst_b)
      gate == BPF_RUN && !oc_comp |-> pwm_out == pwm_in)
      else $error("drive not restored");

   // reaching the threshold at a cycle boundary latches the shutdown
   shut_entry_a: assert property (@(posedge mclk) disable iff (!rst_b)
      stat_blank && pwm_cycle_start && limit_hit |=> stat_shut)
      else $error("no shutdown at threshold");

   // a clean cycle start in run restarts the consecutive count
   run_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
      gate == BPF_RUN && pwm_cycle_start |=> hit_cnt == '0)
      else $error("fault run not cleared");

   // each sample leaves output and prior output equal, with valid set
   filt_upd_a: assert property (@(posedge mclk) disable iff (!rst_b)
      adc_valid |=> filter_out_now == filter_out_prev && filter_valid)
      else $error("filter state mismatch");

   // the output register carries the value of the update equation
   filt_eq_a: assert property (@(posedge mclk) disable iff (!rst_b)
      adc_valid |=> filter_out_now == $past(next_filter_out))
      else $error("filter equation wrong");

   // without a sample the filter state must not move
   filt_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !adc_valid |=> $stable(filter_out_prev) && $stable(sample_prev))
      else $error("state moved without sample");

   // the stamp holds the time base value of the sensing edge
   stamp_capture_a: assert property (@(posedge mclk) disable iff (!rst_b)
      adc_valid |=> stamp_valid && bemf_stamp == $past(stamp_timer))
      else $error("stamp wrong");

   // the stamp only moves on a sensing event
   stamp_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !adc_valid |=> $stable(bemf_stamp) && !stamp_valid)
      else $error("stamp moved without event");
endmodule
`default_nettype wire

// >>> tb/bpf_stage_model.sv
// power stage and current comparator model facing the gate outputs
`timescale 1ns/10ps
`default_nettype none
module bpf_stage_model (
   input  wire logic [5:0] gate_drive,
   input  wire logic       overload,
   output logic [5:0]      gate_seen,
   output logic            oc_comp
);
   // mosfet gates follow the drive with no clock in between
   assign gate_seen = gate_drive;
   // comparator is a plain level: it never waits for a clock edge
   assign oc_comp   = overload;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the loop filter and overcurrent gate
`timescale 1ns/10ps
`default_nettype none
module tb;
   import bpf_pkg::*;
   logic mclk = 0, clk_en = 1, rst_b = 0, adc_valid = 0, use_def = 0;
   logic [11:0] adc_data = 12'h800;
   logic signed [15:0] c0 = 16'sh0100, c1 = 16'sh0080;   // manual coefficients
   logic cyc = 0, overload = 0, shut_clear = 0;
   logic [5:0] pwm_in = 6'h2a, pwm_out, gate_seen;
   logic [7:0] trip = 8'h04;
   logic oc, f_valid, s_valid, st_blank, st_shut;
   logic signed [23:0] y_out;
   logic [15:0] stamp;
   logic [15:0] stamp_last = 16'h0000;   // stamp of the previous sample
   int n_errors = 0, checks_done = 0, y_ref = 0, prev_ref = 0, n_smp = 0;
   // clock may be halted to show blanking does not need it
   always #5 mclk = clk_en ? ~mclk : mclk;
   bpf_top dut (.mclk(mclk), .rst_b(rst_b), .adc_data(adc_data), .adc_valid(adc_valid),
      .coef_current(c0), .coef_previous(c1), .use_default_coef(use_def),
      .pwm_cycle_start(cyc), .pwm_in(pwm_in), .oc_comp(oc), .trip_count(trip),
      .shut_clear(shut_clear), .pwm_out(pwm_out), .filter_out_now(y_out),
      .filter_valid(f_valid), .bemf_stamp(stamp), .stamp_valid(s_valid),
      .stat_blank(st_blank), .stat_shut(st_shut));
   bpf_stage_model stage (.gate_drive(pwm_out), .overload(overload),
      .gate_seen(gate_seen), .oc_comp(oc));
   task automatic step(); @(posedge mclk); #1; endtask
   // compare a data word
   task automatic cmp_word(string nm, logic [23:0] e, logic [23:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // compare a single flag
   task automatic cmp_bit(string nm, logic e, logic g);
      cmp_word(nm, {23'h0, e}, {23'h0, g});
   endtask
   // send one sample and judge the filter answer one cycle later
   // samples are two cycles apart, so consecutive stamps differ by two
   task automatic sample(logic [11:0] a, int k_now, int k_prev);
      int smp;
      smp = int'(a) - int'(BPF_MID_CODE);   // midpoint referenced sample
      y_ref = y_ref + ((k_now * smp - k_prev * prev_ref) >>> BPF_FRAC_W);
      prev_ref = smp;
      adc_data = a;
      adc_valid = 1;
      step();
      adc_valid = 0;
      cmp_bit("filter_valid", 1'b1, f_valid);
      cmp_bit("stamp_valid", 1'b1, s_valid);
      cmp_word("filter_out_now", y_ref[23:0], y_out);
      if (n_smp > 0) begin
         cmp_word("bemf_stamp step", 24'h000002, {8'h00, 16'(stamp - stamp_last)});
      end
      stamp_last = stamp;
      n_smp++;
      step();
      cmp_bit("filter_valid drop", 1'b0, f_valid);
   endtask
   task automatic pulse_cycle(); cyc = 1; step(); cyc = 0; step(); endtask
   // wait bounded for the synchronised fault to show as blanking
   task automatic wait_blank();
      for (int i = 0; i < 12 && !st_blank; i++) step();
      cmp_bit("stat_blank", 1'b1, st_blank);
   endtask
   task automatic filter_test();
      sample(12'h810, c0, c1);
      sample(12'h7f0, c0, c1);
      sample(12'h800, c0, c1);
      use_def = 1;   // built-in coefficients from the time constants
      sample(12'h840, BPF_COEF_CUR_INT, BPF_COEF_PREV_INT);
      sample(12'h7c0, BPF_COEF_CUR_INT, BPF_COEF_PREV_INT);
   endtask
   // halted clock, cycle blanking, then recovery at next cycle start
   task automatic blank_test();
      clk_en = 0; overload = 1; #3;
      cmp_word("pwm_out stopped clk", 24'h0, {18'h0, gate_seen});
      clk_en = 1; step();
      cmp_word("pwm_out fault", 24'h0, {18'h0, pwm_out});
      wait_blank();
      overload = 0;
      // the synchronised level needs four edges to fall; blank stands meanwhile
      repeat (5) step();
      cmp_bit("stat_blank held", 1'b1, st_blank);
      cmp_word("pwm_out stretched", 24'h0, {18'h0, pwm_out});
      pulse_cycle();
      cmp_bit("stat_blank", 1'b0, st_blank);
      cmp_word("pwm_out resumed", {18'h0, pwm_in}, {18'h0, pwm_out});
   endtask
   // persistent fault escalates to a latched shutdown
   task automatic shut_test();
      pulse_cycle(); // clean cycle breaks the earlier faulted run
      trip = 8'h03; overload = 1; step(); wait_blank();
      pulse_cycle(); pulse_cycle();
      cmp_bit("stat_shut early", 1'b0, st_shut);
      pulse_cycle();
      cmp_bit("stat_shut", 1'b1, st_shut);
      overload = 0; pulse_cycle();
      cmp_bit("stat_shut latched", 1'b1, st_shut);
      cmp_word("pwm_out shut", 24'h0, {18'h0, pwm_out});
      // the fault is still seen through the synchroniser: clear is refused
      shut_clear = 1;
      step();
      cmp_bit("stat_shut clear refused", 1'b1, st_shut);
      shut_clear = 0;
      repeat (4) step();
      shut_clear = 1;
      step();
      shut_clear = 0;
      step();
      cmp_bit("stat_shut cleared", 1'b0, st_shut);
      cmp_word("pwm_out clear", {18'h0, pwm_in}, {18'h0, pwm_out});
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // watchdog: whole run is about fifty cycles
   initial begin
      #100us;
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge mclk);
      #1 rst_b = 1;
      step();
      filter_test();
      blank_test();
      shut_test();
      end_of_test();
   end
endmodule
`default_nettype wire
